/* File: logic/odu_update_ctrl.sv */
// update, mask, power-down, reset and reference control of an octal converter
// Behaviour
// - strobe high during write: outputs hold; strobe falling edge afterwards updates them
// - power-down word needs code 0100, bit 19 zero; two mode bits per channel
// - code 0101 loads the 8-bit load mask from low data bits, address ignored
// - mask bit clear follows strobe; mask bit set ignores all strobe transitions
// - mask all ones blocks strobe falling-edge updates on every channel; writes with strobe low still reach outputs
// - code 0001 writes input register; output also only when strobe is low
// - code 0010 copies input register to output register, strobe level ignored
// - code 0011 writes input and output registers, strobe level ignored
// - each strobe falling edge copies input to output on unmasked channels
// - with strobe held low the mask bits are disregarded
// - reset pin low clears outputs to zero or midscale per level select pin
// - reset pin low blocks updates; cleared value holds until reprogrammed
// - strobe activity ignored during power-on reset interval; reset pin low pauses its count
// - reset pin low at power-up defers initialisation until it is released
// - power-up outputs at zero or midscale per level select, held until write
// - code 0110 restores power-on state only with address 0 and key 1234
// - reference on after power-up; bit 0 set turns it off, clear turns on
// - bit 2 selects gain two when set; ignored on variants without gain bit
// - code 0111 sets reference and gain, address ignored, bit 1 written zero
// - channel commands pick the target channel from the address field
// - mode bits: 00 normal, 01 pull to ground, 10 and 11 high impedance
module odu_update_ctrl #(
  parameter bit GAIN_BIT_USED = 1'b1
) (
  // core clock and reset
  input  wire logic                  MCLK_IN,
  input  wire logic                  RSTN_IN,
  // command link
  input  wire logic                  LINK_CLK_IN,
  input  wire logic                  CMD_VALID_IN,
  input  wire odu_pkg::odu_cmd_t     CMD_WORD_IN,
  // device pins
  input  wire logic                  LOAD_STROBE_N_IN,
  input  wire logic                  HW_RESET_N_IN,
  input  wire logic                  RESET_LEVEL_SELECT_IN,
  // converter state
  output odu_pkg::odu_codes_t        CHANNEL_CODE_OUT,
  output odu_pkg::odu_codes_t        INPUT_CODE_OUT,
  output logic [15:0]                POWER_DOWN_MODES_OUT,
  output logic [7:0]                 CHANNEL_PULLDOWN_OUT,
  output logic [7:0]                 CHANNEL_HIZ_OUT,
  output logic [7:0]                 LOAD_MASK_OUT,
  output odu_pkg::odu_refgain_t      REF_GAIN_OUT,
  output logic                       READY_OUT
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic chan_hit(input odu_pkg::odu_cmd_t c, input int i);
    chan_hit = (c.channel_select_bits == 4'(i));
  endfunction

  function automatic logic [15:0] clear_code(input logic mid);
    clear_code = mid ? odu_pkg::CODE_MID_SCALE : odu_pkg::CODE_ZERO_SCALE;
  endfunction

  // ----------------------------------------
  // link domain capture
  // ----------------------------------------
  odu_pkg::odu_cmd_t word_link_reg;
  logic              tog_link_reg;

  always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      word_link_reg <= '0;
    end else if (CMD_VALID_IN) begin
      word_link_reg <= CMD_WORD_IN;
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tog_link_reg <= 1'b0;
    end else if (CMD_VALID_IN) begin
      tog_link_reg <= ~tog_link_reg;
    end
  end

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
  logic ld_s1_reg, ld_s2_reg, ld_s3_reg;
  logic hr_s1_reg, hr_s2_reg;
  logic rs_s1_reg, rs_s2_reg;

  always_ff @(posedge MCLK_IN) begin
    tog_s1_reg <= tog_link_reg;
    tog_s2_reg <= tog_s1_reg;
    ld_s1_reg  <= LOAD_STROBE_N_IN;
    ld_s2_reg  <= ld_s1_reg;
    hr_s1_reg  <= HW_RESET_N_IN;
    hr_s2_reg  <= hr_s1_reg;
    rs_s1_reg  <= RESET_LEVEL_SELECT_IN;
    rs_s2_reg  <= rs_s1_reg;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      tog_s3_reg <= tog_s2_reg;
      ld_s3_reg  <= 1'b1;
    end else begin
      tog_s3_reg <= tog_s2_reg;
      ld_s3_reg  <= ld_s2_reg;
    end
  end

  // ----------------------------------------
  // command register
  // ----------------------------------------
  odu_pkg::odu_cmd_t cmd_reg;
  logic              cmd_pend_reg;

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      cmd_reg      <= '0;
      cmd_pend_reg <= 1'b0;
    end else begin
      cmd_pend_reg <= tog_s2_reg ^ tog_s3_reg;
      if (tog_s2_reg ^ tog_s3_reg) begin
        cmd_reg <= word_link_reg;
      end
    end
  end

  // ----------------------------------------
  // power-on sequence
  // ----------------------------------------
  odu_pkg::odu_por_state_t por_state_reg;
  logic [7:0]              por_cnt_reg;

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      por_state_reg <= odu_pkg::POR_WAIT;
      por_cnt_reg   <= 8'h00;
    end else begin
      unique case (por_state_reg)
        odu_pkg::POR_WAIT: begin
          if (hr_s2_reg) begin
            if (por_cnt_reg == odu_pkg::POR_CYCLES - 8'h01) begin
              por_state_reg <= odu_pkg::POR_INIT;
            end
            por_cnt_reg <= por_cnt_reg + 8'h01;
          end
        end
        odu_pkg::POR_INIT: begin
          por_state_reg <= odu_pkg::POR_RUN;
        end
        odu_pkg::POR_RUN: begin
          por_state_reg <= odu_pkg::POR_RUN;
        end
        default: begin
          por_state_reg <= odu_pkg::POR_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic       run;
  logic       upd_ok;
  logic       exec;
  logic       strobe_fall;
  logic       sw_reset;
  logic [2:0] cmd_ch;

  assign run         = (por_state_reg == odu_pkg::POR_RUN);
  assign upd_ok      = run && hr_s2_reg;
  assign exec        = cmd_pend_reg && upd_ok;
  assign strobe_fall = ld_s3_reg && !ld_s2_reg && upd_ok;
  assign cmd_ch      = cmd_reg.channel_select_bits[2:0];
  assign sw_reset    = exec && (cmd_reg.command_code_bits == odu_pkg::CMD_SOFT_RESET) &&
                       (cmd_reg.channel_select_bits == odu_pkg::SOFT_RESET_ADDR) &&
                       (cmd_reg.data == odu_pkg::SOFT_RESET_KEY);

  // ----------------------------------------
  // input and output registers
  // ----------------------------------------
  odu_pkg::odu_codes_t in_reg;
  odu_pkg::odu_codes_t dac_reg;
  logic [7:0]          mask_reg;

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      in_reg  <= '0;
      dac_reg <= '0;
    end else if ((por_state_reg == odu_pkg::POR_INIT) || sw_reset) begin
      for (int i = 0; i < odu_pkg::NUM_CHANNELS; i++) begin
        in_reg[i]  <= clear_code(rs_s2_reg);
        dac_reg[i] <= clear_code(rs_s2_reg);
      end
    end else if (run && !hr_s2_reg) begin
      for (int i = 0; i < odu_pkg::NUM_CHANNELS; i++) begin
        in_reg[i]  <= clear_code(rs_s2_reg);
        dac_reg[i] <= clear_code(rs_s2_reg);
      end
    end else if (run) begin
      for (int i = 0; i < odu_pkg::NUM_CHANNELS; i++) begin
        if (exec && chan_hit(cmd_reg, i) &&
            ((cmd_reg.command_code_bits == odu_pkg::CMD_WRITE_INPUT) ||
             (cmd_reg.command_code_bits == odu_pkg::CMD_WRITE_UPDATE))) begin
          in_reg[i] <= cmd_reg.data;
        end
        if (exec && chan_hit(cmd_reg, i) &&
            (cmd_reg.command_code_bits == odu_pkg::CMD_WRITE_UPDATE)) begin
          dac_reg[i] <= cmd_reg.data;
        end else if (exec && chan_hit(cmd_reg, i) &&
                     (cmd_reg.command_code_bits == odu_pkg::CMD_UPDATE_DAC)) begin
          dac_reg[i] <= in_reg[i];
        end else if (exec && chan_hit(cmd_reg, i) && !ld_s2_reg &&
                     (cmd_reg.command_code_bits == odu_pkg::CMD_WRITE_INPUT)) begin
          dac_reg[i] <= cmd_reg.data;
        end else if (strobe_fall && !mask_reg[i]) begin
          dac_reg[i] <= in_reg[i];
        end
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [15:0]           pd_reg;
  logic [7:0]            pull_reg;
  logic [7:0]            hiz_reg;
  odu_pkg::odu_refgain_t refgain_reg;

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN || sw_reset) begin
      mask_reg <= odu_pkg::MASK_RESET;
    end else if (exec && (cmd_reg.command_code_bits == odu_pkg::CMD_LOAD_MASK)) begin
      mask_reg <= cmd_reg.data[7:0];
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN || sw_reset) begin
      pd_reg   <= odu_pkg::PD_RESET;
      pull_reg <= 8'h00;
      hiz_reg  <= 8'h00;
    end else if (exec && (cmd_reg.command_code_bits == odu_pkg::CMD_POWER_DOWN) &&
                 !cmd_reg.channel_select_bits[odu_pkg::PD_ZERO_BIT]) begin
      pd_reg <= cmd_reg.data;
      for (int i = 0; i < odu_pkg::NUM_CHANNELS; i++) begin
        pull_reg[i] <= cmd_reg.data[2*i] && !cmd_reg.data[2*i+1];
        hiz_reg[i]  <= cmd_reg.data[2*i+1];
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN || sw_reset) begin
      refgain_reg <= '0;
    end else if (exec && (cmd_reg.command_code_bits == odu_pkg::CMD_REF_GAIN)) begin
      refgain_reg.ref_off  <= cmd_reg.data[odu_pkg::REF_OFF_BIT];
      refgain_reg.reserved <= 1'b0;
      refgain_reg.gain_two <= cmd_reg.data[odu_pkg::GAIN_BIT] && GAIN_BIT_USED;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign CHANNEL_CODE_OUT     = dac_reg;
  assign INPUT_CODE_OUT       = in_reg;
  assign POWER_DOWN_MODES_OUT = pd_reg;
  assign CHANNEL_PULLDOWN_OUT = pull_reg;
  assign CHANNEL_HIZ_OUT      = hiz_reg;
  assign LOAD_MASK_OUT        = mask_reg;
  assign REF_GAIN_OUT         = refgain_reg;
  assign READY_OUT            = run;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);

  logic [15:0] sel_in;
  logic [15:0] sel_dac;
  logic        hit0;
  logic [3:0]  code;

  assign sel_in  = in_reg[cmd_ch];
  assign sel_dac = dac_reg[cmd_ch];
  assign hit0    = exec && chan_hit(cmd_reg, 0);
  assign code    = cmd_reg.command_code_bits;

  chk_deferred_write_hold: assert property (
    exec && code == odu_pkg::CMD_WRITE_INPUT && ld_s2_reg && !strobe_fall &&
    cmd_reg.channel_select_bits < 4'h8
    |=> dac_reg[$past(cmd_ch)] == $past(sel_dac) &&
        in_reg[$past(cmd_ch)] == $past(cmd_reg.data))
    else $error("deferred write changed output or missed input");

  chk_write_update: assert property (
    exec && code == odu_pkg::CMD_WRITE_UPDATE && cmd_reg.channel_select_bits < 4'h8
    |=> dac_reg[$past(cmd_ch)] == $past(cmd_reg.data) &&
        in_reg[$past(cmd_ch)] == $past(cmd_reg.data))
    else $error("write and update did not load both registers");

  chk_copy_input: assert property (
    exec && code == odu_pkg::CMD_UPDATE_DAC && cmd_reg.channel_select_bits < 4'h8
    |=> dac_reg[$past(cmd_ch)] == $past(sel_in) && $stable(in_reg))
    else $error("update from input register wrong");

  chk_mask_load: assert property (
    exec && code == odu_pkg::CMD_LOAD_MASK |=> mask_reg == $past(cmd_reg.data[7:0]))
    else $error("load mask not taken");

  chk_fall_update: assert property (
    strobe_fall && !mask_reg[0] && !hit0 |=> dac_reg[0] == $past(in_reg[0]))
    else $error("strobe edge did not update unmasked channel");

  chk_masked_hold: assert property (
    strobe_fall && mask_reg[0] && !hit0 && !sw_reset |=> $stable(dac_reg[0]))
    else $error("masked channel followed strobe");

  chk_reset_clear: assert property (
    run && !hr_s2_reg ##1 !hr_s2_reg |-> dac_reg[0] == clear_code($past(rs_s2_reg)))
    else $error("reset pin did not clear output");

  chk_por_defer: assert property (
    por_state_reg == odu_pkg::POR_WAIT && !hr_s2_reg |=> por_state_reg == odu_pkg::POR_WAIT &&
    $stable(dac_reg))
    else $error("initialisation not deferred");

  chk_soft_reset_key: assert property (
    exec && code == odu_pkg::CMD_SOFT_RESET && !sw_reset
    |=> $stable(mask_reg) && $stable(pd_reg) && $stable(refgain_reg))
    else $error("bad soft reset key changed state");

  chk_power_down: assert property (
    exec && code == odu_pkg::CMD_POWER_DOWN &&
    !cmd_reg.channel_select_bits[odu_pkg::PD_ZERO_BIT]
    |=> pd_reg == $past(cmd_reg.data) && hiz_reg[0] == pd_reg[1])
    else $error("power-down word not applied");

  chk_direct_write: assert property (
    exec && code == odu_pkg::CMD_WRITE_INPUT && !ld_s2_reg &&
    cmd_reg.channel_select_bits < 4'h8
    |=> dac_reg[$past(cmd_ch)] == $past(cmd_reg.data) &&
        in_reg[$past(cmd_ch)] == $past(cmd_reg.data))
    else $error("write with strobe low did not reach output");

  chk_ref_setup: assert property (
    exec && code == odu_pkg::CMD_REF_GAIN
    |=> refgain_reg.ref_off == $past(cmd_reg.data[odu_pkg::REF_OFF_BIT]) &&
        !refgain_reg.reserved &&
        (!GAIN_BIT_USED || refgain_reg.gain_two == $past(cmd_reg.data[odu_pkg::GAIN_BIT])))
    else $error("reference and gain setup not applied");

  chk_soft_reset_apply: assert property (
    sw_reset |=> dac_reg[0] == clear_code($past(rs_s2_reg)) &&
                 in_reg[0] == clear_code($past(rs_s2_reg)) &&
                 mask_reg == odu_pkg::MASK_RESET && pd_reg == odu_pkg::PD_RESET)
    else $error("soft reset did not restore power-on state");

  chk_power_up_level: assert property (
    por_state_reg == odu_pkg::POR_INIT
    |=> run && dac_reg[0] == clear_code($past(rs_s2_reg)) &&
        in_reg[0] == clear_code($past(rs_s2_reg)))
    else $error("power-up level not loaded");

  cov_strobe_edge: cover property (strobe_fall && mask_reg == 8'h00);
  cov_direct_write: cover property (exec && code == odu_pkg::CMD_WRITE_INPUT && !ld_s2_reg);
  cov_write_update: cover property (exec && code == odu_pkg::CMD_WRITE_UPDATE);
  cov_soft_reset: cover property (sw_reset);
  cov_reset_pin: cover property (run && !hr_s2_reg);

endmodule

/* File: logic/odu_pkg.sv */
// constants, types and command codes of the octal converter update control
package odu_pkg;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
  localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN   = 4'h4;
  localparam logic [3:0] CMD_LOAD_MASK    = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;
  localparam logic [3:0] CMD_REF_GAIN     = 4'h7;

  // ----------------------------------------
  // field positions and keys
  // ----------------------------------------
  localparam int          NUM_CHANNELS     = 8;
  localparam int          CODE_WIDTH       = 16;
  localparam int          PD_ZERO_BIT      = 3;
  localparam int          REF_OFF_BIT      = 0;
  localparam int          GAIN_BIT         = 2;
  localparam logic [3:0]  SOFT_RESET_ADDR  = 4'h0;
  localparam logic [15:0] SOFT_RESET_KEY   = 16'h1234;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] CODE_ZERO_SCALE  = 16'h0000;
  localparam logic [15:0] CODE_MID_SCALE   = 16'h8000;
  localparam logic [7:0]  MASK_RESET       = 8'h00;
  localparam logic [15:0] PD_RESET         = 16'h0000;

  // ----------------------------------------
  // power-on reset timing
  // ----------------------------------------
  localparam int          POR_TIME_NS      = 160;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam logic [7:0]  POR_CYCLES       = 8'((POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]  command_code_bits;
    logic [3:0]  channel_select_bits;
    logic [15:0] data;
  } odu_cmd_t;

  typedef struct packed {
    logic gain_two;
    logic reserved;
    logic ref_off;
  } odu_refgain_t;

  typedef logic [7:0][15:0] odu_codes_t;

  typedef enum logic [1:0] {
    POR_WAIT = 2'b00,
    POR_INIT = 2'b01,
    POR_RUN  = 2'b10
  } odu_por_state_t;

endpackage

/* File: verification/odu_link_model.sv */
// serial controller model: assembles command words and pulses them over the link
module odu_link_model (
  // link pins
  output logic              link_clk_out,
  output logic              valid_out,
  output odu_pkg::odu_cmd_t word_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // idle link
  // ----------------------------------------
  initial begin
    link_clk_out = 1'b0;
    valid_out = 1'b0;
    word_out = '0;
  end

  // ----------------------------------------
  // one word per frame, clock stands low between frames
  // ----------------------------------------
  task automatic send(input logic [7:0] cmd_b, input logic [7:0] msb_b, input logic [7:0] lsb_b);
    word_out = {cmd_b, msb_b, lsb_b};
    valid_out = 1'b1;
    #62.5 link_clk_out = 1'b1;
    #62.5 link_clk_out = 1'b0;
    valid_out = 1'b0;
    // released word shows no stale value
    word_out = ~{cmd_b, msb_b, lsb_b};
  endtask
endmodule

/* File: verification/octal_dac_update_control_test.sv */
// self-checking bench of the octal converter update control
module octal_dac_update_control_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                  mclk;
  logic                  rstn;
  logic                  strobe_n;
  logic                  hw_rst_n;
  logic                  lvl_sel;
  logic                  link_clk;
  logic                  cmd_valid;
  odu_pkg::odu_cmd_t     cmd_word;
  odu_pkg::odu_codes_t   code_o;
  odu_pkg::odu_codes_t   in_o;
  logic [15:0]           pd_o;
  logic [7:0]            pull_o;
  logic [7:0]            hiz_o;
  logic [7:0]            mask_o;
  odu_pkg::odu_refgain_t rg_o;
  logic                  ready;
  int                    mismatches;
  int                    n_tests;

  odu_link_model link (.link_clk_out(link_clk), .valid_out(cmd_valid), .word_out(cmd_word));

  odu_update_ctrl uut (
    .MCLK_IN(mclk), .RSTN_IN(rstn), .LINK_CLK_IN(link_clk), .CMD_VALID_IN(cmd_valid),
    .CMD_WORD_IN(cmd_word), .LOAD_STROBE_N_IN(strobe_n), .HW_RESET_N_IN(hw_rst_n),
    .RESET_LEVEL_SELECT_IN(lvl_sel), .CHANNEL_CODE_OUT(code_o), .INPUT_CODE_OUT(in_o),
    .POWER_DOWN_MODES_OUT(pd_o), .CHANNEL_PULLDOWN_OUT(pull_o), .CHANNEL_HIZ_OUT(hiz_o),
    .LOAD_MASK_OUT(mask_o), .REF_GAIN_OUT(rg_o), .READY_OUT(ready)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    link.send({c, a}, d[15:8], d[7:0]);
    tick(10);
  endtask

  task automatic pulse;
    strobe_n = 1'b0;
    tick(4);
    strobe_n = 1'b1;
    tick(6);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_por;
    tick(40);
    chk({15'h0, ready}, 16'h0);
    pulse();
    hw_rst_n = 1'b1;
    tick(2);
    chk({15'h0, ready}, 16'h0);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) tick(1);
    if (ready !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: ready timeout", $time);
      stop_test();
    end
    for (int i = 0; i < 8; i++) chk(code_o[i], odu_pkg::CODE_MID_SCALE);
    chk({13'h0, rg_o}, 16'h0);
    chk({8'h0, mask_o}, {8'h0, odu_pkg::MASK_RESET});
    $display("test power-up done");
  endtask

  task automatic t_defer;
    cmd(odu_pkg::CMD_WRITE_INPUT, 4'h3, 16'ha5c3);
    cmd(odu_pkg::CMD_WRITE_INPUT, 4'h5, 16'h0ff1);
    chk(in_o[3], 16'ha5c3);
    chk(code_o[3], odu_pkg::CODE_MID_SCALE);
    chk(in_o[2], odu_pkg::CODE_MID_SCALE);
    pulse();
    chk(code_o[3], 16'ha5c3);
    chk(code_o[5], 16'h0ff1);
    $display("test deferred update done");
  endtask

  task automatic t_mask;
    cmd(odu_pkg::CMD_LOAD_MASK, 4'hf, 16'hff05);
    chk({8'h0, mask_o}, 16'h0005);
    cmd(odu_pkg::CMD_WRITE_INPUT, 4'h0, 16'h1111);
    cmd(odu_pkg::CMD_WRITE_INPUT, 4'h1, 16'h2222);
    pulse();
    chk(code_o[0], odu_pkg::CODE_MID_SCALE);
    chk(code_o[1], 16'h2222);
    cmd(odu_pkg::CMD_LOAD_MASK, 4'h0, 16'h00ff);
    cmd(odu_pkg::CMD_WRITE_INPUT, 4'h1, 16'h3333);
    pulse();
    chk(code_o[1], 16'h2222);
    strobe_n = 1'b0;
    tick(4);
    cmd(odu_pkg::CMD_WRITE_INPUT, 4'h1, 16'h4444);
    chk(code_o[1], 16'h4444);
    strobe_n = 1'b1;
    tick(4);
    cmd(odu_pkg::CMD_LOAD_MASK, 4'h0, 16'h0000);
    $display("test load mask done");
  endtask

  task automatic t_cmds;
    cmd(odu_pkg::CMD_UPDATE_DAC, 4'h0, 16'hdead);
    chk(code_o[0], 16'h1111);
    chk(in_o[0], 16'h1111);
    cmd(odu_pkg::CMD_WRITE_UPDATE, 4'h6, 16'hbeef);
    chk(code_o[6], 16'hbeef);
    chk(in_o[6], 16'hbeef);
    cmd(odu_pkg::CMD_WRITE_UPDATE, 4'h9, 16'h0bad);
    chk(code_o[1], 16'h4444);
    $display("test direct commands done");
  endtask

  task automatic t_pd;
    cmd(odu_pkg::CMD_POWER_DOWN, 4'h5, 16'hc00d);
    chk(pd_o, 16'hc00d);
    chk({8'h0, pull_o}, 16'h0001);
    chk({8'h0, hiz_o}, 16'h0082);
    cmd(odu_pkg::CMD_POWER_DOWN, 4'h8, 16'h0000);
    chk(pd_o, 16'hc00d);
    $display("test power-down done");
  endtask

  task automatic t_ref;
    cmd(odu_pkg::CMD_REF_GAIN, 4'ha, 16'hfff9);
    chk({13'h0, rg_o}, 16'h0001);
    cmd(odu_pkg::CMD_REF_GAIN, 4'h0, 16'h0004);
    chk({13'h0, rg_o}, 16'h0004);
    $display("test reference setup done");
  endtask

  task automatic t_soft;
    cmd(odu_pkg::CMD_SOFT_RESET, 4'h0, 16'h1235);
    cmd(odu_pkg::CMD_SOFT_RESET, 4'h1, odu_pkg::SOFT_RESET_KEY);
    chk(pd_o, 16'hc00d);
    chk(code_o[0], 16'h1111);
    chk({13'h0, rg_o}, 16'h0004);
    cmd(odu_pkg::CMD_SOFT_RESET, odu_pkg::SOFT_RESET_ADDR, odu_pkg::SOFT_RESET_KEY);
    chk(code_o[0], odu_pkg::CODE_MID_SCALE);
    chk(in_o[6], odu_pkg::CODE_MID_SCALE);
    chk(pd_o, odu_pkg::PD_RESET);
    chk({13'h0, rg_o}, 16'h0000);
    $display("test soft reset done");
  endtask

  task automatic t_hw;
    cmd(odu_pkg::CMD_WRITE_UPDATE, 4'h2, 16'h7777);
    lvl_sel = 1'b0;
    hw_rst_n = 1'b0;
    tick(6);
    chk(code_o[2], odu_pkg::CODE_ZERO_SCALE);
    cmd(odu_pkg::CMD_WRITE_UPDATE, 4'h2, 16'h5555);
    chk(code_o[2], odu_pkg::CODE_ZERO_SCALE);
    hw_rst_n = 1'b1;
    tick(6);
    chk(code_o[2], odu_pkg::CODE_ZERO_SCALE);
    chk(in_o[2], odu_pkg::CODE_ZERO_SCALE);
    $display("test hardware reset done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    strobe_n = 1'b1;
    hw_rst_n = 1'b0;
    lvl_sel = 1'b1;
    mismatches = 0;
    n_tests = 0;
    tick(4);
    rstn = 1'b1;
    t_por();
    t_defer();
    t_mask();
    t_cmds();
    t_pd();
    t_ref();
    t_soft();
    t_hw();
    stop_test();
  end
endmodule
